// ===== verilog/tmr8_pkg.sv
// Package of the 8-bit auto-reload timer with PWM output.
// Assumes a 32-bit AHB-Lite bus; register indices are word numbers.
package tmr8_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE   = 8'hdc;
  localparam logic [7:0] IDX_COUNT  = 8'hdd;
  localparam logic [7:0] IDX_RELOAD = 8'hde;
  localparam logic [7:0] IDX_STATUS = 8'hdf;
  localparam logic [7:0] IDX_DUTY   = 8'hea;

  // Mode register fields
  localparam int MODE_ENABLE_BIT = 7;
  localparam int MODE_RATE_HI    = 6;
  localparam int MODE_RATE_LO    = 4;
  localparam int MODE_CKSEL_BIT  = 2;
  localparam int MODE_PWM_BIT    = 0;

  // Status register fields
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_IEN_BIT  = 1;

  localparam logic [7:0] CNT_FULL   = 8'hff;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] PRE_TOP    = 8'h80;
  localparam logic [1:0] HTRANS_NSQ = 2'h2;

  typedef struct packed {
    logic       enable;
    logic [2:0] rate;
    logic       cksel;
    logic       pwm_en;
  } tmr8_mode_t;

  typedef struct packed {
    tmr8_mode_t mode;
    logic [7:0] count;
    logic [7:0] reload_buf;
    logic [7:0] reload_act;
    logic [7:0] duty;
    logic       flag;
    logic       ien;
    logic       pwm_lvl;
    logic [6:0] pre_cnt;
    logic       dp_wr;
    logic [7:0] dp_idx;
  } tmr8_state_t;

endpackage

// ===== verilog/tmr8_timer.sv
// 8-bit up timer with double-buffered auto-reload, overflow flag and PWM.
// Assumes an AHB-Lite master on sys_clk_i and a one-cycle instruction
// clock strobe; the high-speed oscillator is sys_clk_i itself.
//
// Operation
// (RULE1) Overflow sets flag; software clears it
// (RULE2) Overflow reloads count from active reload
// (RULE3) Reload writes buffered, applied at overflow
// (RULE4) Software writes count equal reload first
// (RULE5) Software computes start as 256 minus ticks
// (RULE6) PWM goes high at each overflow
// (RULE7) Count equal duty drives PWM low
// (RULE8) Overflow is wrap from full scale
// (RULE9) Duty not above reload keeps PWM low
// (RULE10) PWM shown only when timer, PWM enabled
// (RULE11) PWM enable switches pin from GPIO
// (RULE12) Overflow raises interrupt when enabled
// (RULE13) Period change applies from next cycle
// (RULE14) Resolution follows reload value
// (RULE15) Software sets duty as reload plus width
// (RULE16) Counter stops when disabled, else counts
// (RULE17) Clock select picks oscillator or prescaled
// (RULE18) Prescaler field divides 128 down to 1
// (RULE19) Buffer moves to active before count load
// (RULE20) Reload reads zero without side effect
`timescale 1ns/1ps

module tmr8_timer (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        cpu_tick_i,
  input  wire logic        gpio_out_i,
  input  wire logic        gpio_oe_i,
  output logic             pin_out_o,
  output logic             pin_oe_o,
  output logic             irq_o
);

  tmr8_pkg::tmr8_state_t st_ff;
  tmr8_pkg::tmr8_state_t nxt_st;

  logic       addr_ok;
  logic       src_tick;
  logic       tick;
  logic       ovf;
  logic [6:0] pre_max;
  logic [7:0] wbyte;
  logic [7:0] pre_top;

  assign wbyte   = hwdata_i[7:0];
  assign addr_ok = hsel_i && hready_i && (htrans_i == tmr8_pkg::HTRANS_NSQ);
  assign pre_top = tmr8_pkg::PRE_TOP >> st_ff.mode.rate;
  assign pre_max = 7'(pre_top - 8'h01); // RULE18

  // Fhosc is sys_clk_i, so the oscillator source ticks every cycle
  assign src_tick = st_ff.mode.cksel ? 1'b1 // RULE17
                  : (cpu_tick_i && (st_ff.pre_cnt == pre_max));
  assign tick     = st_ff.mode.enable && src_tick; // RULE16
  assign ovf      = tick && (st_ff.count == tmr8_pkg::CNT_FULL); // RULE8

  always_comb begin
    nxt_st = st_ff;
    nxt_st.dp_wr = 1'b0;
    // Prescaler runs only while counting from the instruction clock
    if (!st_ff.mode.enable || st_ff.mode.cksel) begin
      nxt_st.pre_cnt = 7'h00;
    end else if (cpu_tick_i) begin
      nxt_st.pre_cnt = (st_ff.pre_cnt == pre_max) ? 7'h00
                     : st_ff.pre_cnt + 7'h01; // RULE18
    end
    if (tick) begin
      nxt_st.count = st_ff.count + 8'h01; // RULE16
    end
    if (ovf) begin
      nxt_st.reload_act = st_ff.reload_buf; // RULE3 RULE19
      nxt_st.count      = st_ff.reload_buf; // RULE2 RULE13 RULE14
      nxt_st.pwm_lvl    = (st_ff.duty > st_ff.reload_buf); // RULE6 RULE9
    end else if (tick && (nxt_st.count == st_ff.duty)) begin
      nxt_st.pwm_lvl = 1'b0; // RULE7
    end
    // Data phase of a write commits here
    if (st_ff.dp_wr) begin
      unique case (st_ff.dp_idx)
        tmr8_pkg::IDX_MODE: begin
          nxt_st.mode.enable =
            wbyte[tmr8_pkg::MODE_ENABLE_BIT];
          nxt_st.mode.rate =
            wbyte[tmr8_pkg::MODE_RATE_HI:tmr8_pkg::MODE_RATE_LO];
          nxt_st.mode.cksel  = wbyte[tmr8_pkg::MODE_CKSEL_BIT];
          nxt_st.mode.pwm_en = wbyte[tmr8_pkg::MODE_PWM_BIT];
          // A fresh enable starts the PWM cycle high if duty is above the buffer. The buffer is used,
          // not the active reload: before the first overflow only the
          // buffer holds the period that software set up.
          if (wbyte[tmr8_pkg::MODE_ENABLE_BIT] && !st_ff.mode.enable) begin
            nxt_st.pwm_lvl = (st_ff.duty > st_ff.reload_buf); // RULE6 RULE9
          end
        end
        // Software write of the count wins over a same-cycle reload
        tmr8_pkg::IDX_COUNT:  nxt_st.count      = wbyte;
        tmr8_pkg::IDX_RELOAD: nxt_st.reload_buf = wbyte; // RULE3
        tmr8_pkg::IDX_DUTY:   nxt_st.duty       = wbyte;
        tmr8_pkg::IDX_STATUS: begin
          nxt_st.ien = wbyte[tmr8_pkg::STAT_IEN_BIT];
          // Writing zero clears; an overflow in the same cycle wins
          if (!wbyte[tmr8_pkg::STAT_FLAG_BIT]) begin
            nxt_st.flag = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (ovf) begin
      nxt_st.flag = 1'b1; // RULE1 RULE12
    end
    if (addr_ok) begin
      nxt_st.dp_wr  = hwrite_i;
      nxt_st.dp_idx = haddr_i[9:2];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Reads are answered from the registers in the data phase
  always_comb begin
    hrdata_o = 32'h0000_0000;
    unique case (st_ff.dp_idx)
      tmr8_pkg::IDX_MODE: begin
        hrdata_o[tmr8_pkg::MODE_ENABLE_BIT] = st_ff.mode.enable;
        hrdata_o[tmr8_pkg::MODE_RATE_HI:tmr8_pkg::MODE_RATE_LO] =
          st_ff.mode.rate;
        hrdata_o[tmr8_pkg::MODE_CKSEL_BIT] = st_ff.mode.cksel;
        hrdata_o[tmr8_pkg::MODE_PWM_BIT]   = st_ff.mode.pwm_en;
      end
      tmr8_pkg::IDX_COUNT: hrdata_o[7:0] = st_ff.count;
      tmr8_pkg::IDX_DUTY:  hrdata_o[7:0] = st_ff.duty;
      tmr8_pkg::IDX_STATUS: begin
        hrdata_o[tmr8_pkg::STAT_FLAG_BIT] = st_ff.flag;
        hrdata_o[tmr8_pkg::STAT_IEN_BIT]  = st_ff.ien;
      end
      // Write-only reload and unmapped words read zero
      default: hrdata_o = 32'h0000_0000; // RULE20
    endcase
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign irq_o       = st_ff.flag && st_ff.ien; // RULE12

  // GPIO setting is untouched while PWM owns the pin, so it returns as was
  assign pin_out_o = st_ff.mode.pwm_en ? // RULE11
                     (st_ff.mode.enable && st_ff.pwm_lvl) // RULE10
                   : gpio_out_i;
  assign pin_oe_o  = st_ff.mode.pwm_en ? 1'b1 : gpio_oe_i; // RULE11

  // Checks
  a_ovf_sets_flag: assert property (@(posedge sys_clk_i) // RULE1
    disable iff (!reset_n_i) ovf |=> st_ff.flag)
    else $error("Overflow did not set the flag");

  a_flag_holds: assert property (@(posedge sys_clk_i) // RULE1
    disable iff (!reset_n_i)
    st_ff.flag && !(st_ff.dp_wr && st_ff.dp_idx == tmr8_pkg::IDX_STATUS)
    |=> st_ff.flag)
    else $error("Flag dropped without software clear");

  a_ovf_reloads: assert property (@(posedge sys_clk_i) // RULE2
    disable iff (!reset_n_i)
    ovf && !(st_ff.dp_wr && st_ff.dp_idx == tmr8_pkg::IDX_COUNT)
    |=> st_ff.count == $past(st_ff.reload_buf))
    else $error("Count not loaded from reload at overflow");

  a_buf_held: assert property (@(posedge sys_clk_i) // RULE3
    disable iff (!reset_n_i) !ovf |=> $stable(st_ff.reload_act))
    else $error("Active reload changed without overflow");

  a_pwm_high: assert property (@(posedge sys_clk_i) // RULE6
    disable iff (!reset_n_i)
    ovf && st_ff.duty > st_ff.reload_buf && !st_ff.dp_wr
    |=> st_ff.pwm_lvl)
    else $error("PWM not high after overflow");

  a_pwm_low: assert property (@(posedge sys_clk_i) // RULE7
    disable iff (!reset_n_i)
    tick && !ovf && st_ff.count + 8'h01 == st_ff.duty |=> !st_ff.pwm_lvl)
    else $error("PWM not low at duty match");

  a_stop_hold: assert property (@(posedge sys_clk_i) // RULE16
    disable iff (!reset_n_i)
    !st_ff.mode.enable && !st_ff.dp_wr |=> $stable(st_ff.count))
    else $error("Counter moved while disabled");

  a_pin_gated: assert property (@(posedge sys_clk_i) // RULE10
    disable iff (!reset_n_i)
    st_ff.mode.pwm_en && !st_ff.mode.enable |-> !pin_out_o && pin_oe_o)
    else $error("PWM pin active while timer disabled");

  a_irq_req: assert property (@(posedge sys_clk_i) // RULE12
    disable iff (!reset_n_i) ovf |=> irq_o == st_ff.ien)
    else $error("Interrupt request does not follow its enable");

  a_gpio_back: assert property (@(posedge sys_clk_i) // RULE11
    disable iff (!reset_n_i)
    !st_ff.mode.pwm_en |-> pin_out_o == gpio_out_i && pin_oe_o == gpio_oe_i)
    else $error("Pin not returned to GPIO");

  // Flag is never set by software, only by a wrap from full scale
  a_flag_source: assert property (@(posedge sys_clk_i) // RULE1
    disable iff (!reset_n_i)
    !st_ff.flag && !ovf |=> !st_ff.flag)
    else $error("Flag set without overflow");

  a_flag_clear: assert property (@(posedge sys_clk_i) // RULE1
    disable iff (!reset_n_i)
    st_ff.dp_wr && st_ff.dp_idx == tmr8_pkg::IDX_STATUS && !ovf &&
    !hwdata_i[tmr8_pkg::STAT_FLAG_BIT]
    |=> !st_ff.flag)
    else $error("Flag not cleared by software");

  a_wrap_full: assert property (@(posedge sys_clk_i) // RULE8
    disable iff (!reset_n_i)
    $rose(st_ff.flag) |-> $past(st_ff.count) == tmr8_pkg::CNT_FULL)
    else $error("Overflow taken away from full scale");

  // Bus side: every write lands at the end of its data phase
  a_buf_write: assert property (@(posedge sys_clk_i) // RULE3
    disable iff (!reset_n_i)
    st_ff.dp_wr && st_ff.dp_idx == tmr8_pkg::IDX_RELOAD
    |=> st_ff.reload_buf == $past(hwdata_i[7:0]))
    else $error("Reload write did not reach the buffer");

  a_act_update: assert property (@(posedge sys_clk_i) // RULE19
    disable iff (!reset_n_i)
    ovf |=> st_ff.reload_act == $past(st_ff.reload_buf))
    else $error("Active reload not taken from buffer");

  // Software count write wins over a reload in the same cycle
  a_count_write: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    st_ff.dp_wr && st_ff.dp_idx == tmr8_pkg::IDX_COUNT
    |=> st_ff.count == $past(hwdata_i[7:0]))
    else $error("Count write lost");

  a_duty_write: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    st_ff.dp_wr && st_ff.dp_idx == tmr8_pkg::IDX_DUTY
    |=> st_ff.duty == $past(hwdata_i[7:0]))
    else $error("Duty write lost");

  a_ien_write: assert property (@(posedge sys_clk_i) // RULE12
    disable iff (!reset_n_i)
    st_ff.dp_wr && st_ff.dp_idx == tmr8_pkg::IDX_STATUS
    |=> st_ff.ien == $past(hwdata_i[tmr8_pkg::STAT_IEN_BIT]))
    else $error("Interrupt enable write lost");

  a_count_step: assert property (@(posedge sys_clk_i) // RULE16
    disable iff (!reset_n_i)
    tick && !ovf && !(st_ff.dp_wr && st_ff.dp_idx == tmr8_pkg::IDX_COUNT)
    |=> st_ff.count == $past(st_ff.count) + 8'h01)
    else $error("Count did not step by one");

  // Clock source and prescaler
  a_osc_ticks: assert property (@(posedge sys_clk_i) // RULE17
    disable iff (!reset_n_i)
    st_ff.mode.enable && st_ff.mode.cksel |-> tick)
    else $error("Oscillator source missed a tick");

  a_pre_hold: assert property (@(posedge sys_clk_i) // RULE18
    disable iff (!reset_n_i)
    !st_ff.mode.cksel && !cpu_tick_i |-> !tick)
    else $error("Prescaled count moved without an instruction tick");

  a_pre_wrap: assert property (@(posedge sys_clk_i) // RULE18
    disable iff (!reset_n_i)
    tick && !st_ff.mode.cksel |=> st_ff.pre_cnt == 7'h00)
    else $error("Prescaler not restarted after a tick");

  // PWM level inside one cycle
  a_low_cycle: assert property (@(posedge sys_clk_i) // RULE9
    disable iff (!reset_n_i)
    ovf && st_ff.duty <= st_ff.reload_buf |=> !st_ff.pwm_lvl)
    else $error("PWM high although duty is not above reload");

  a_enable_start: assert property (@(posedge sys_clk_i) // RULE6
    disable iff (!reset_n_i)
    st_ff.dp_wr && st_ff.dp_idx == tmr8_pkg::IDX_MODE &&
    !st_ff.mode.enable && hwdata_i[tmr8_pkg::MODE_ENABLE_BIT]
    |=> st_ff.pwm_lvl == (st_ff.duty > st_ff.reload_buf))
    else $error("PWM cycle did not start on enable");

  a_low_stays: assert property (@(posedge sys_clk_i) // RULE7
    disable iff (!reset_n_i)
    !st_ff.pwm_lvl && !ovf &&
    !(st_ff.dp_wr && st_ff.dp_idx == tmr8_pkg::IDX_MODE)
    |=> !st_ff.pwm_lvl)
    else $error("PWM rose inside a cycle");

  a_high_stays: assert property (@(posedge sys_clk_i) // RULE7
    disable iff (!reset_n_i)
    st_ff.pwm_lvl && !tick &&
    !(st_ff.dp_wr && st_ff.dp_idx == tmr8_pkg::IDX_MODE)
    |=> st_ff.pwm_lvl)
    else $error("PWM fell without a count step");

  a_pin_shows: assert property (@(posedge sys_clk_i) // RULE10
    disable iff (!reset_n_i)
    st_ff.mode.pwm_en && st_ff.mode.enable
    |-> pin_out_o == st_ff.pwm_lvl && pin_oe_o)
    else $error("PWM level not on the pin");

  a_pwm_drives: assert property (@(posedge sys_clk_i) // RULE11
    disable iff (!reset_n_i) st_ff.mode.pwm_en |-> pin_oe_o)
    else $error("Pin not driven while PWM owns it");

  a_reload_zero: assert property (@(posedge sys_clk_i) // RULE20
    disable iff (!reset_n_i)
    st_ff.dp_idx == tmr8_pkg::IDX_RELOAD |-> hrdata_o == 32'h0000_0000)
    else $error("Reload read returned data");

  c_overflow: cover property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) ovf);
  c_pwm_cycle: cover property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) st_ff.mode.pwm_en && $fell(st_ff.pwm_lvl));
  c_prescaled: cover property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) ovf && !st_ff.mode.cksel);
  c_clear_race: cover property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    ovf && st_ff.dp_wr && st_ff.dp_idx == tmr8_pkg::IDX_STATUS);
  c_new_period: cover property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) ovf && st_ff.reload_buf != st_ff.reload_act);

endmodule

// ===== verif/tmr8_load.sv
// External load on the shared PWM pin: measures high time and period.
// Assumes the pin is sampled on the timer clock; first result is junk.
`timescale 1ns/1ps
module tmr8_load (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       pin_i,
  output logic      [9:0] hi_o,
  output logic      [9:0] per_o,
  output logic            done_o
);
  logic       last_ff;
  logic [9:0] hi_ff;
  logic [9:0] per_ff;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {last_ff, hi_ff, per_ff, hi_o, per_o, done_o} <= '0;
    end else begin
      last_ff <= pin_i;
      done_o  <= pin_i & ~last_ff;
      if (pin_i & ~last_ff) begin
        hi_o   <= hi_ff;
        per_o  <= per_ff;
        hi_ff  <= 10'h001;
        per_ff <= 10'h001;
      end else begin
        hi_ff  <= hi_ff + {9'h000, pin_i};
        per_ff <= per_ff + 10'h001;
      end
    end
  end
endmodule

// ===== verif/timer8_autoreload_pwm_test.sv
// Self-checking bench for the 8-bit timer over AHB-Lite.
// Assumes zero-wait slave; hready loops back from hreadyout.
`timescale 1ns/1ps
module timer8_autoreload_pwm_test;
  logic        sys_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic        cpu_tick_i = 1'b0;
  logic        gpio_out_i = 1'b0;
  logic        gpio_oe_i = 1'b0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic        pin_out_o;
  logic        pin_oe_o;
  logic        irq_o;
  logic [9:0]  hi_o;
  logic [9:0]  per_o;
  logic        done_o;
  logic [31:0] q;
  logic [31:0] q2;
  logic [9:0]  hi;
  logic [9:0]  per;
  int          bad_count = 0;
  int          total_checks = 0;
  logic [7:0]  idx_list [6] = '{tmr8_pkg::IDX_MODE, tmr8_pkg::IDX_COUNT,
    tmr8_pkg::IDX_RELOAD, tmr8_pkg::IDX_STATUS, tmr8_pkg::IDX_DUTY, 8'h10};

  tmr8_timer i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .cpu_tick_i(cpu_tick_i), .gpio_out_i(gpio_out_i),
    .gpio_oe_i(gpio_oe_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .irq_o(irq_o));
  tmr8_load i_load (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .pin_i(pin_out_o), .hi_o(hi_o), .per_o(per_o), .done_o(done_o));

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic complete_run();
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic tmo();
    bad_count++;
    $display("BAD %0t wait ran out", $time);
    complete_run();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic edge_ready();
    int n;
    n = 0;
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) begin
      n++;
      if (n > 50) tmo();
      @(posedge sys_clk_i);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [31:0] r);
    hsel_i   <= 1'b1;
    haddr_i  <= {22'h0, idx, 2'h0};
    htrans_i <= tmr8_pkg::HTRANS_NSQ;
    hwrite_i <= w;
    edge_ready();
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, d};
    edge_ready();
    r = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic next_cycle();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (n > 600) tmo();
    end while (done_o !== 1'b1);
    hi = hi_o;
    per = per_o;
  endtask

  initial begin
    repeat (10) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    foreach (idx_list[i]) begin
      bus(1'b0, idx_list[i], 8'h00, q);
      chk(q, 32'h0);
    end
    wr(8'h10, 8'h5a);
    bus(1'b0, 8'h10, 8'h00, q);
    chk(q, 32'h0);
    chk({31'h0, hresp_o}, 32'h0);
    wr(tmr8_pkg::IDX_COUNT, 8'h80);
    wr(tmr8_pkg::IDX_RELOAD, 8'h80);
    wr(tmr8_pkg::IDX_DUTY, 8'h90);
    wr(tmr8_pkg::IDX_MODE, 8'h85);
    bus(1'b0, tmr8_pkg::IDX_RELOAD, 8'h00, q);
    chk(q, 32'h0);
    next_cycle();
    next_cycle();
    next_cycle();
    chk({22'h0, per}, 32'd128);
    chk({22'h0, hi}, 32'd16);
    // New period written mid-cycle must not change the running one
    wr(tmr8_pkg::IDX_RELOAD, 8'h00);
    next_cycle();
    chk({22'h0, per}, 32'd128);
    next_cycle();
    chk({22'h0, per}, 32'd256);
    chk({22'h0, hi}, 32'd144);
    bus(1'b0, tmr8_pkg::IDX_STATUS, 8'h00, q);
    chk(q, 32'h1);
    wr(tmr8_pkg::IDX_STATUS, 8'h02);
    @(posedge sys_clk_i);
    chk({31'h0, irq_o}, 32'h0);
    q = 32'h0;
    while (irq_o !== 1'b1) begin
      @(posedge sys_clk_i);
      q++;
      if (q > 32'd300) tmo();
    end
    chk({31'h0, irq_o}, 32'h1);
    bus(1'b0, tmr8_pkg::IDX_STATUS, 8'h00, q);
    chk(q, 32'h3);
    wr(tmr8_pkg::IDX_STATUS, 8'h00);
    @(posedge sys_clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(tmr8_pkg::IDX_DUTY, 8'h00);
    repeat (260) @(posedge sys_clk_i);
    q = 32'h0;
    repeat (300) begin
      @(posedge sys_clk_i);
      q = q + {31'h0, pin_out_o};
    end
    chk(q, 32'h0);
    gpio_out_i <= 1'b1;
    gpio_oe_i  <= 1'b1;
    wr(tmr8_pkg::IDX_MODE, 8'h84);
    @(posedge sys_clk_i);
    chk({30'h0, pin_out_o, pin_oe_o}, 32'h3);
    bus(1'b0, tmr8_pkg::IDX_COUNT, 8'h00, q);
    bus(1'b0, tmr8_pkg::IDX_COUNT, 8'h00, q2);
    chk({24'h0, q2[7:0] - q[7:0]}, 32'h2);
    wr(tmr8_pkg::IDX_MODE, 8'h01);
    @(posedge sys_clk_i);
    chk({30'h0, pin_out_o, pin_oe_o}, 32'h1);
    bus(1'b0, tmr8_pkg::IDX_COUNT, 8'h00, q);
    bus(1'b0, tmr8_pkg::IDX_COUNT, 8'h00, q2);
    chk(q2 - q, 32'h0);
    // Every divider: three counts need exactly three times its ticks
    for (int r = 0; r < 8; r++) begin
      wr(tmr8_pkg::IDX_MODE, 8'h00);
      wr(tmr8_pkg::IDX_COUNT, 8'h00);
      wr(tmr8_pkg::IDX_MODE, {1'b1, r[2:0], 4'h0});
      repeat ((128 >> r) * 3) begin
        cpu_tick_i <= 1'b1;
        @(posedge sys_clk_i);
        cpu_tick_i <= 1'b0;
        @(posedge sys_clk_i);
      end
      bus(1'b0, tmr8_pkg::IDX_COUNT, 8'h00, q);
      chk(q, 32'h3);
    end
    complete_run();
  end
endmodule
